// file: logic/adcs_sequencer.sv
// Purpose: SAR sequencer, status/control and result registers on AHB-Lite
// Assumes: mclk is the converter clock; analog array answers each cycle
// Notes:   zero wait states; response always OKAY
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "adcs_defines.svh"

module adcs_sequencer (
   // Clock, reset, enable
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic                   clk_en,
   // AHB-Lite slave
   input  wire adcs_pkg::adcs_ahb_in_t ahb_in,
   output adcs_pkg::adcs_ahb_out_t     ahb_out,
   // Analog array
   input  wire logic                   cmp_out,
   output adcs_pkg::adcs_analog_t      analog,
   // Port sharing
   input  wire logic [9:0]             port_pin_in,
   output logic [9:0]                  port_takeover,
   output logic [9:0]                  port_read_data,
   // Interrupt to CPU
   output logic                        conv_irq
);
   import adcs_pkg::*;

   adcs_regs_t cur_ff;
   adcs_regs_t nxt_cur;
   logic [9:0] pin_meta_ff;
   logic [9:0] pin_sync_ff;

   logic       wr_scr;
   logic       wr_cfg;
   logic       rd_rh;
   logic       rd_rl;
   logic       conv_end;
   logic [9:0] final_code;
   logic       powered;
   logic [31:0] rd_word;

   // Pins arrive from another domain; the comparator is launched by the
   // array on mclk, so a sync stage would skew it from the trial code
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_meta_ff <= 10'h000;
         pin_sync_ff <= 10'h000;
      end else if (clk_en) begin
         pin_meta_ff <= port_pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Data phase decode of the registered address phase
   assign wr_scr = cur_ff.ap_valid && cur_ff.ap_write &&
                   cur_ff.ap_addr == `ADCS_OFF_SCR;
   assign wr_cfg = cur_ff.ap_valid && cur_ff.ap_write &&
                   cur_ff.ap_addr == `ADCS_OFF_CFG;
   assign rd_rh  = cur_ff.ap_valid && !cur_ff.ap_write &&
                   cur_ff.ap_addr == `ADCS_OFF_RH;
   assign rd_rl  = cur_ff.ap_valid && !cur_ff.ap_write &&
                   cur_ff.ap_addr == `ADCS_OFF_RL;

   assign powered  = cur_ff.chan != `ADCS_CH_OFF;
   assign conv_end = cur_ff.state == ST_CONV && cur_ff.bitn == 4'h0;
   assign final_code = {cur_ff.sar[9:1], cmp_out};

   // Read mux works on the new address phase so data is ready next cycle
   always_comb begin
      rd_word = 32'h0000_0000;
      case (ahb_in.haddr[11:0])
         `ADCS_OFF_SCR:
            rd_word[7:0] = {cur_ff.done, cur_ff.ien, cur_ff.cont,
                            cur_ff.chan};
         `ADCS_OFF_RH:  rd_word[7:0] = cur_ff.rh;
         `ADCS_OFF_RL:  rd_word[7:0] = cur_ff.rl;
         `ADCS_OFF_CFG: rd_word[1:0] = cur_ff.fmt;
         `ADCS_OFF_PORT: begin
            rd_word[9:0] = pin_sync_ff;
            if (cur_ff.chan <= `ADCS_CH_LAST_PIN)
               rd_word[cur_ff.chan[3:0]] = 1'b0;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.ap_valid = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1];
      nxt_cur.ap_write = ahb_in.hwrite;
      nxt_cur.ap_addr  = ahb_in.haddr[11:0];
      if (ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1] &&
          !ahb_in.hwrite)
         nxt_cur.rdata = rd_word;

      if (wr_cfg)
         nxt_cur.fmt = ahb_in.hwdata[1:0];

      case (cur_ff.state)
         ST_OFF: begin
            nxt_cur.settle = 1'b1;
         end
         ST_IDLE: ;
         ST_ALIGN: begin
            if (cur_ff.bitn != 4'h0) begin
               nxt_cur.bitn = cur_ff.bitn - 4'h1;
            end else begin
               nxt_cur.state = ST_CONV;
               nxt_cur.bitn  = 4'h9;
               nxt_cur.sar   = 10'h200;
            end
         end
         ST_CONV: begin
            if (cur_ff.bitn != 4'h0) begin
               nxt_cur.sar = cur_ff.sar & ~(10'h001 << cur_ff.bitn);
               if (cmp_out)
                  nxt_cur.sar[cur_ff.bitn] = 1'b1;
               nxt_cur.sar[cur_ff.bitn - 4'h1] = 1'b1;
               nxt_cur.bitn = cur_ff.bitn - 4'h1;
            end
         end
         default: nxt_cur.state = ST_IDLE;
      endcase

      // data read clears; placed first so a same-cycle end wins
      if (rd_rh || rd_rl) begin
         nxt_cur.done = 1'b0;
         nxt_cur.irq  = 1'b0;
      end

      if (conv_end) begin
         nxt_cur.settle = 1'b0;
         if (!cur_ff.settle) begin
            if (!cur_ff.lock || cur_ff.fmt == `ADCS_FMT_TRUNC) begin
               case (cur_ff.fmt)
                  `ADCS_FMT_TRUNC: begin
                     nxt_cur.rh = 8'h00;
                     nxt_cur.rl = final_code[9:2];
                  end
                  `ADCS_FMT_RIGHT: begin
                     nxt_cur.rh = {6'h00, final_code[9:8]};
                     nxt_cur.rl = final_code[7:0];
                  end
                  `ADCS_FMT_LEFT: begin
                     nxt_cur.rh = final_code[9:2];
                     nxt_cur.rl = {final_code[1:0], 6'h00};
                  end
                  default: begin
                     nxt_cur.rh = {~final_code[9], final_code[8:2]};
                     nxt_cur.rl = {final_code[1:0], 6'h00};
                  end
               endcase
            end
         end
         // done sets; continuous first only; not with interrupts
         if (!cur_ff.ien && (!cur_ff.cont || cur_ff.first))
            nxt_cur.done = 1'b1;
         nxt_cur.first = 1'b0;
         if (cur_ff.ien)
            nxt_cur.irq = 1'b1;
         if (cur_ff.cont) begin
            nxt_cur.state = ST_ALIGN;
            nxt_cur.bitn  = `ADCS_ALIGN_CYC;
         end else begin
            nxt_cur.state = ST_IDLE;
         end
      end

      // high read locks except in truncation, low read unlocks
      if (rd_rh && cur_ff.fmt != `ADCS_FMT_TRUNC)
         nxt_cur.lock = 1'b1;
      if (rd_rl)
         nxt_cur.lock = 1'b0;

      if (wr_scr) begin
         nxt_cur.ien   = ahb_in.hwdata[`ADCS_SCR_IEN];
         nxt_cur.cont  = ahb_in.hwdata[`ADCS_SCR_CONT];
         nxt_cur.chan  = ahb_in.hwdata[4:0];
         nxt_cur.irq   = 1'b0;
         nxt_cur.first = 1'b1;
         nxt_cur.done  = ahb_in.hwdata[`ADCS_SCR_IEN] &
                         ahb_in.hwdata[`ADCS_SCR_DONE];
         if (ahb_in.hwdata[4:0] == `ADCS_CH_OFF)
            nxt_cur.state = ST_OFF;
         else
            nxt_cur.state = ST_ALIGN;
         nxt_cur.bitn = `ADCS_ALIGN_CYC;
         if (cur_ff.state == ST_OFF)
            nxt_cur.settle = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cur_ff          <= '0;
         cur_ff.state    <= ST_OFF;
         cur_ff.chan     <= `ADCS_CH_OFF;
         cur_ff.fmt      <= `ADCS_CFG_RST;
         cur_ff.settle   <= 1'b1;
      end else if (clk_en) begin
         cur_ff <= nxt_cur;
      end
   end

   // Bus answers in zero wait states
   assign ahb_out.hrdata    = cur_ff.rdata;
   assign ahb_out.hreadyout = 1'b1;
   assign ahb_out.hresp     = 1'b0;

   // no wait gating; irq is the flag alone, it can be high while done is high
   assign conv_irq = cur_ff.irq;

   assign analog.trial_chan = cur_ff.chan;
   assign analog.trial_code = cur_ff.sar;
   assign analog.power_on   = powered;
   assign analog.sample     = cur_ff.state == ST_CONV;

   genvar gi;
   generate
      for (gi = 0; gi < `ADCS_NUM_PINS; gi++) begin : g_pin
         assign port_takeover[gi] = cur_ff.chan == 5'(gi);
         assign port_read_data[gi] = (cur_ff.chan == 5'(gi)) ? 1'b0 :
                                     pin_sync_ff[gi];
      end
   endgenerate

   conv_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && cur_ff.state == ST_CONV && cur_ff.bitn != 4'h0 && !wr_scr
      |=> cur_ff.bitn == $past(cur_ff.bitn) - 4'h1)
      else $error("bit step skipped");
   irq_after_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && cur_ff.ien && !wr_scr && !rd_rh && !rd_rl
      |=> conv_irq)
      else $error("no interrupt after conversion");
   write_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && wr_scr && ahb_in.hwdata[4:0] != `ADCS_CH_OFF
      |=> cur_ff.state == ST_ALIGN)
      else $error("write did not restart");
   read_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && (rd_rh || rd_rl) && !wr_scr && !conv_end
      |=> !cur_ff.done && !conv_irq)
      else $error("read did not clear done");
   power_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
      cur_ff.chan == `ADCS_CH_OFF |-> !analog.power_on && !analog.sample)
      else $error("converter on while off");
   right_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && cur_ff.fmt == `ADCS_FMT_RIGHT
      |=> cur_ff.rh[7:2] == 6'h00)
      else $error("right format upper bits set");
   lock_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && cur_ff.lock && !rd_rl && cur_ff.fmt != `ADCS_FMT_TRUNC
      && !wr_cfg |=> $stable(cur_ff.rl))
      else $error("locked low byte changed");
   conv_span_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && cur_ff.state == ST_ALIGN && cur_ff.bitn == 4'h0 && !wr_scr
      |=> (cur_ff.bitn == 4'h9) && cur_ff.state == ST_CONV)
      else $error("conversion did not begin");
   pin_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      cur_ff.chan <= `ADCS_CH_LAST_PIN |->
      port_read_data[cur_ff.chan[3:0]] == 1'b0)
      else $error("selected pin read nonzero");
   single_stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && !cur_ff.cont && !wr_scr
      |=> cur_ff.state == ST_IDLE)
      else $error("single conversion did not stop");
   align_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && cur_ff.state == ST_ALIGN && cur_ff.bitn != 4'h0 && !wr_scr
      |=> cur_ff.state == ST_ALIGN
      && cur_ff.bitn == $past(cur_ff.bitn) - 4'h1)
      else $error("alignment count broken");
   irq_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && wr_scr |=> !conv_irq)
      else $error("interrupt kept after write");
   done_ien_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && cur_ff.ien && !wr_scr && !rd_rh && !rd_rl
      |=> cur_ff.done == $past(cur_ff.done))
      else $error("done moved with interrupts on");
   cont_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && cur_ff.cont && !wr_scr
      |=> cur_ff.state == ST_ALIGN)
      else $error("continuous run stopped");
   settle_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && cur_ff.settle |=> $stable(cur_ff.rl))
      else $error("settling result stored");
   takeover_a: assert property (@(posedge mclk) disable iff (sys_rst)
      cur_ff.chan <= `ADCS_CH_LAST_PIN
      |-> port_takeover == (10'h001 << cur_ff.chan))
      else $error("wrong pin taken over");
   trunc_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && conv_end && !cur_ff.settle
      && cur_ff.fmt == `ADCS_FMT_TRUNC
      |=> cur_ff.rh == 8'h00)
      else $error("truncation upper byte set");
endmodule // adcs_sequencer

// file: include/adcs_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: AHB-Lite word registers at byte addresses
// Notes:   included by its bare name
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH
`define ADCS_OFF_SCR      12'h000
`define ADCS_OFF_RH       12'h004
`define ADCS_OFF_RL       12'h008
`define ADCS_OFF_CFG      12'h00C
`define ADCS_OFF_PORT     12'h010
`define ADCS_SCR_DONE     7
`define ADCS_SCR_IEN      6
`define ADCS_SCR_CONT     5
`define ADCS_SCR_RST      8'h1F
`define ADCS_CFG_RST      2'h1
`define ADCS_CH_OFF       5'h1F
`define ADCS_CH_VREFH     5'h1D
`define ADCS_CH_VREFL     5'h1E
`define ADCS_CH_LAST_PIN  5'h09
`define ADCS_NUM_PINS     10
`define ADCS_RES_BITS     10
`define ADCS_CONV_CYC     16
// Six alignment clocks plus ten bit clocks make the sixteen
`define ADCS_ALIGN_CYC    4'h5
`define ADCS_FMT_TRUNC    2'h0
`define ADCS_FMT_RIGHT    2'h1
`define ADCS_FMT_LEFT     2'h2
`define ADCS_FMT_SIGN     2'h3
`endif

// file: include/adcs_pkg.sv
// Purpose: shared types of the converter sequencer
// Assumes: constants live in adcs_defines.svh
// Notes:   state is carried as one packed struct
package adcs_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_ALIGN, ST_CONV} adcs_state_t;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hsel;
      logic        hready;
      logic [31:0] hwdata;
   } adcs_ahb_in_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } adcs_ahb_out_t;

   typedef struct packed {
      logic [4:0]  trial_chan;
      logic [9:0]  trial_code;
      logic        power_on;
      logic        sample;
   } adcs_analog_t;

   typedef struct packed {
      adcs_state_t state;
      logic        done;
      logic        ien;
      logic        cont;
      logic [4:0]  chan;
      logic [1:0]  fmt;
      logic [9:0]  sar;
      logic [3:0]  bitn;
      logic        first;
      logic        settle;
      logic [7:0]  rh;
      logic [7:0]  rl;
      logic        lock;
      logic        ap_valid;
      logic        ap_write;
      logic [11:0] ap_addr;
      logic [31:0] rdata;
      logic        irq;
   } adcs_regs_t;
endpackage

// file: verification/adcs_analog_model.sv
// Purpose: analog array and comparator stand-in
// Assumes: comparator answers on the live trial code
// Notes:   output churns while the array is idle
`timescale 1ns/1ps
module adcs_analog_model (
   // Clock
   input  wire logic                   mclk,
   // Array control and pin levels
   input  wire adcs_pkg::adcs_analog_t ana,
   input  wire logic [9:0]             lvl [10],
   // Comparator
   output logic                        cmp
);
   import adcs_pkg::*;
   logic [9:0] vin;
   logic       tgl = 1'b0;
   always_comb begin
      vin = 10'h000;
      if (ana.trial_chan <= 5'h09) begin
         vin = lvl[ana.trial_chan];
      end
      if (ana.trial_chan == 5'h1D) begin
         vin = 10'h3FF;
      end
   end
   // Idle output flips so a stale sample is never a free match
   always @(posedge mclk) begin
      tgl <= ~tgl;
   end
   assign cmp = (ana.power_on && ana.sample) ? (vin >= ana.trial_code) : tgl;
endmodule // adcs_analog_model

// file: verification/tb_adc_sequencer_control.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: zero-wait bus slave, 16-cycle conversions
// Notes:   first conversion after reset only settles
`timescale 1ns/1ps
`include "adcs_defines.svh"
module tb_adc_sequencer_control;
   import adcs_pkg::*;
   typedef struct packed {
      logic [1:0] fmt;
      logic [4:0] ch;
      logic       has_rh;
      logic [7:0] rh;
      logic [7:0] rl;
   } adcs_row_t;
   localparam logic [11:0] A_SCR = `ADCS_OFF_SCR;
   localparam logic [11:0] A_RH = `ADCS_OFF_RH;
   localparam logic [11:0] A_RL = `ADCS_OFF_RL;
   localparam logic [11:0] A_CFG = `ADCS_OFF_CFG;
   logic          mclk = 1'b0;
   logic          sys_rst = 1'b1;
   logic          clk_en = 1'b1;
   logic [31:0]   haddr = 32'h0;
   logic [1:0]    htrans = 2'h0;
   logic          hwrite = 1'b0;
   logic          hsel = 1'b0;
   logic [31:0]   hwdata = 32'h0;
   adcs_ahb_in_t  bi;
   adcs_ahb_out_t bo;
   adcs_analog_t  ana;
   logic          cmp;
   logic [9:0]    lvl [10];
   logic [9:0]    pins = 10'h3FF;
   logic [9:0]    take;
   logic [9:0]    pview;
   logic [9:0]    oh;
   logic          irq;
   logic [31:0]   r;
   int            error_cnt = 0;
   int            n_checks = 0;
   adcs_row_t     rows [8] = '{
      '{2'h1, 5'h00, 1'b1, 8'h02, 8'hD6},
      '{2'h2, 5'h00, 1'b1, 8'hB5, 8'h80},
      '{2'h3, 5'h00, 1'b1, 8'h35, 8'h80},
      '{2'h0, 5'h00, 1'b0, 8'h00, 8'hB5},
      '{2'h1, 5'h09, 1'b1, 8'h01, 8'h55},
      '{2'h2, 5'h09, 1'b1, 8'h55, 8'h40},
      '{2'h1, 5'h1D, 1'b1, 8'h03, 8'hFF},
      '{2'h1, 5'h1E, 1'b1, 8'h00, 8'h00}};

   always #50 mclk = ~mclk;
   assign bi = {haddr, htrans, hwrite, 3'h2, hsel, bo.hreadyout, hwdata};

   adcs_sequencer i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .ahb_in(bi), .ahb_out(bo), .cmp_out(cmp), .analog(ana),
      .port_pin_in(pins), .port_takeover(take),
      .port_read_data(pview), .conv_irq(irq));
   adcs_analog_model i_ana (.mclk(mclk), .ana(ana), .lvl(lvl), .cmp(cmp));

   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask

   // One single transfer; read data lands in r
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [7:0] d = 8'h00);
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel <= 1'b1;
      do @(posedge mclk); while (bo.hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      do @(posedge mclk); while (bo.hreadyout !== 1'b1);
      r = bo.hrdata;
   endtask

   task automatic wdone;
      r = 32'h0;
      repeat (40) if (r[7] !== 1'b1) bus(1'b0, A_SCR);
      chk("done", r[7], 1'b1);
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      for (int i = 0; i < 10; i++) lvl[i] = 10'h155;
      lvl[0] = 10'h2D6;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      bus(1'b0, A_SCR);
      chk("scr_rst", r, 32'h1F);
      bus(1'b0, A_CFG);
      chk("cfg_rst", r, 32'h1);
      chk("pwr_rst", ana.power_on, 1'b0);
      bus(1'b0, 12'h0FC);
      chk("unmapped", r, 32'h0);
      bus(1'b1, A_SCR, 8'h00);
      wdone();
      bus(1'b0, A_RL);
      chk("settle", r, 32'h0);
      foreach (rows[i]) begin
         bus(1'b1, A_CFG, {6'h0, rows[i].fmt});
         bus(1'b1, A_SCR, {3'h0, rows[i].ch});
         wdone();
         chk("idle", ana.sample, 1'b0);
         chk("mux", ana.trial_chan, rows[i].ch);
         if (rows[i].has_rh) begin
            bus(1'b0, A_RH);
            chk("rh", r, rows[i].rh);
         end
         bus(1'b0, A_RL);
         chk("rl", r, rows[i].rl);
         oh = (rows[i].ch < 5'h0A) ? (10'h1 << rows[i].ch) : 10'h0;
         chk("take", take, oh);
         bus(1'b0, `ADCS_OFF_PORT);
         chk("pview", r, pins & ~oh);
      end
      // Upper read freezes lower until lower is read
      bus(1'b1, A_SCR, 8'h00);
      wdone();
      bus(1'b0, A_RH);
      chk("rh_a", r, 32'h2);
      lvl[0] <= 10'h0C3;
      bus(1'b1, A_SCR, 8'h00);
      wdone();
      bus(1'b0, A_RL);
      chk("rl_lock", r, 32'hD6);
      bus(1'b1, A_SCR, 8'h00);
      wdone();
      bus(1'b0, A_RH);
      chk("rh_new", r, 32'h0);
      bus(1'b0, A_RL);
      chk("rl_new", r, 32'hC3);
      // Continuous mode overwrites unread results
      bus(1'b1, A_SCR, 8'h20);
      wdone();
      lvl[0] <= 10'h3A5;
      repeat (30) @(posedge mclk);
      repeat (20) if (ana.sample !== 1'b1) @(posedge mclk);
      chk("running", ana.sample, 1'b1);
      bus(1'b0, A_RL);
      chk("rl_cont", r, 32'hA5);
      // Restart before the first run could finish
      bus(1'b1, A_SCR, 8'h00);
      repeat (6) @(posedge mclk);
      bus(1'b1, A_SCR, 8'h00);
      repeat (4) @(posedge mclk);
      bus(1'b0, A_SCR);
      chk("abort", r[7], 1'b0);
      wdone();
      bus(1'b1, A_SCR, 8'h40);
      repeat (40) if (irq !== 1'b1) @(posedge mclk);
      chk("irq", irq, 1'b1);
      bus(1'b0, A_RL);
      @(posedge mclk);
      chk("irq_clr", irq, 1'b0);
      // Clock enable low freezes a running conversion
      bus(1'b1, A_SCR, 8'h40);
      clk_en <= 1'b0;
      repeat (40) @(posedge mclk);
      chk("frozen", irq, 1'b0);
      clk_en <= 1'b1;
      repeat (40) if (irq !== 1'b1) @(posedge mclk);
      chk("thawed", irq, 1'b1);
      bus(1'b1, A_SCR, 8'hC0);
      bus(1'b0, A_SCR);
      chk("done_wr", r[7:6], 2'h3);
      bus(1'b1, A_SCR, 8'h1F);
      @(posedge mclk);
      chk("pwr_off", ana.power_on, 1'b0);
      end_sim();
   end

   // Whole run needs several hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      end_sim();
   end
endmodule // tb_adc_sequencer_control
